//--- shared/sbq_pkg.sv
// Purpose: constants and carriers for the status byte and error queue
// Assumes: one clock domain, command strobes come from the same clock
// Notes: codes are 16-bit two's complement
package sbq_pkg;
  localparam int unsigned SBQ_DEPTH = 10;
  localparam int unsigned SBQ_PTR_W = 4;
  localparam int unsigned SBQ_CODE_W = 16;
  typedef logic signed [SBQ_CODE_W-1:0] sbq_code_t;
  typedef logic [SBQ_PTR_W-1:0] sbq_ptr_t;
  localparam sbq_ptr_t SBQ_DEPTH_P = 4'hA;
  localparam sbq_ptr_t SBQ_PTR_ZERO = 4'h0;
  localparam sbq_ptr_t SBQ_PTR_ONE = 4'h1;
  // error codes
  localparam sbq_code_t SBQ_CODE_NONE = 16'h0000;
  localparam sbq_code_t SBQ_CODE_SYNTAX = 16'hFF9A;
  localparam sbq_code_t SBQ_CODE_NO_TRIG = 16'h00CE;
  localparam sbq_code_t SBQ_CODE_OVERFLOW = 16'hFEA2;
  // status byte bit positions
  localparam int unsigned SBQ_BIT_PROT = 1;
  localparam int unsigned SBQ_BIT_QUEUE = 2;
  localparam int unsigned SBQ_BIT_MAV = 4;
  localparam int unsigned SBQ_BIT_ESR = 5;
  localparam int unsigned SBQ_BIT_RQS = 6;
  localparam logic [7:0] SBQ_UNUSED_BITS = 8'h89;
  localparam logic [7:0] SBQ_SRE_RESET = 8'h00;
  localparam logic [7:0] SBQ_SRE_WMASK = 8'hBF;
  localparam logic [7:0] SBQ_STB_RESET = 8'h00;

  typedef struct packed {
    logic prot_event;
    logic esr_any;
    logic mav;
    logic gpib_sel;
  } sbq_status_s;

  typedef struct packed {
    logic cls;
    logic err_query;
    logic err_push;
    logic syntax_err;
    logic trigger_type_command_cmd;
    logic trig_armed;
    logic get_cmd;
    logic sre_wr;
    logic esr_read;
    logic poll_done;
  } sbq_cmd_s;
endpackage : sbq_pkg

//--- src/sbq_status_core.sv
// Purpose: summary status byte, service request logic and error/event queue
// Assumes: status_in and cmd_in come from logic on ref_clk_in; strobes are one cycle
// Notes: status and poll bytes lag status_in by one clock; bits 2 and 5 lag the push or event by two
//
// Overview of operation
// - bit 1 set while the protection event input is present
// - bit 2 set whenever any code enters the error queue
// - bits 0, 3 and 7 always read zero
// - bit 4 shows a waiting output message, only on the GPIB interface
// - bit 5 set while standard events pending, cleared by reading that register
// - serial poll byte carries RQS in bit 6, cleared once sent
// - status query returns MSS in bit 6, never in serial poll bytes
// - only bits enabled in the host-written mask feed the request
// - queue stores at most ten entries
// - error query returns oldest entry and removes it
// - clear-status command discards every queued entry
// - codes are signed 16-bit values
// - error query on empty queue returns code zero
// - unrecognised command or data type queues code -102
// - trigger-type command with nothing armed queues 206; GET does not
// - full queue: last entry becomes -350, newer codes dropped
// - query emptying queue clears bit 2; serial poll touches only RQS
`timescale 1ns/1ps
module sbq_status_core (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire sbq_pkg::sbq_status_s status_in,
  input wire sbq_pkg::sbq_cmd_s cmd_in,
  input wire sbq_pkg::sbq_code_t err_code_in,
  input wire logic [7:0] sre_data_in,
  output logic [7:0] stb_out,
  output logic [7:0] poll_byte_out,
  output logic srq_out,
  output logic [7:0] sre_out,
  output sbq_pkg::sbq_code_t err_code_out,
  output logic err_valid_out,
  output logic [3:0] queue_count_out
);
  import sbq_pkg::*;

  function automatic sbq_ptr_t sbq_wrap(input sbq_ptr_t base, input sbq_ptr_t add);
    logic [SBQ_PTR_W:0] sum;
    sum = {1'b0, base} + {1'b0, add};
    if (sum >= {1'b0, SBQ_DEPTH_P}) begin
      sum = sum - {1'b0, SBQ_DEPTH_P};
    end
    return sum[SBQ_PTR_W-1:0];
  endfunction : sbq_wrap

  sbq_code_t mem [SBQ_DEPTH];
  sbq_ptr_t rd_reg, rd_next;
  sbq_ptr_t count_reg, count_next;
  logic q_flag_reg, q_flag_next;
  logic esr_flag_reg, esr_flag_next;
  logic rqs_reg, rqs_next;
  logic svc_prev_reg;
  logic [7:0] sre_reg;
  logic [7:0] stb_base;
  logic wr_en;
  sbq_ptr_t wr_idx;
  sbq_code_t wr_code;

  // push and pop decode
  wire trig_no_arm = cmd_in.trigger_type_command_cmd & ~cmd_in.trig_armed;
  wire push_req = cmd_in.syntax_err | trig_no_arm | cmd_in.err_push;
  wire pop = cmd_in.err_query & (count_reg != SBQ_PTR_ZERO);
  wire sbq_ptr_t cnt_after_pop = pop ? count_reg - SBQ_PTR_ONE : count_reg;
  wire queue_full = (cnt_after_pop == SBQ_DEPTH_P);
  // only one code enters per cycle; parser errors take precedence
  wire sbq_code_t push_code = cmd_in.syntax_err ? SBQ_CODE_SYNTAX :
    trig_no_arm ? SBQ_CODE_NO_TRIG : err_code_in;

  always_comb begin
    rd_next = rd_reg;
    count_next = count_reg;
    wr_en = 1'b0;
    wr_idx = rd_reg;
    wr_code = push_code;
    if (cmd_in.cls) begin
      // a code arriving with the clear survives it
      rd_next = SBQ_PTR_ZERO;
      wr_idx = SBQ_PTR_ZERO;
      wr_en = push_req;
      count_next = push_req ? SBQ_PTR_ONE : SBQ_PTR_ZERO;
    end else begin
      rd_next = pop ? sbq_wrap(rd_reg, SBQ_PTR_ONE) : rd_reg;
      if (push_req) begin
        wr_en = 1'b1;
        if (queue_full) begin
          wr_idx = sbq_wrap(rd_next, SBQ_DEPTH_P - SBQ_PTR_ONE);
          wr_code = SBQ_CODE_OVERFLOW;
        end else begin
          wr_idx = sbq_wrap(rd_next, cnt_after_pop);
          count_next = cnt_after_pop + SBQ_PTR_ONE;
        end
      end else begin
        count_next = cnt_after_pop;
      end
    end
  end

  // set wins over clear on every sticky flag
  wire q_clear = cmd_in.cls | (pop & (count_next == SBQ_PTR_ZERO));
  assign q_flag_next = push_req | (q_flag_reg & ~q_clear);
  wire esr_clear = cmd_in.esr_read | cmd_in.cls;
  assign esr_flag_next = status_in.esr_any | (esr_flag_reg & ~esr_clear);

  always_comb begin
    stb_base = SBQ_STB_RESET;
    stb_base[SBQ_BIT_PROT] = status_in.prot_event;
    stb_base[SBQ_BIT_QUEUE] = q_flag_reg;
    stb_base[SBQ_BIT_MAV] = status_in.mav & status_in.gpib_sel;
    stb_base[SBQ_BIT_ESR] = esr_flag_reg;
  end

  // bit 6 of the mask is not writable, so it never feeds itself
  wire svc = |(stb_base & sre_reg);
  wire svc_rise = svc & ~svc_prev_reg;
  assign rqs_next = svc_rise | (rqs_reg & ~cmd_in.poll_done);

  always_ff @(posedge ref_clk_in) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_code;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_reg <= SBQ_PTR_ZERO;
      count_reg <= SBQ_PTR_ZERO;
      q_flag_reg <= 1'b0;
      esr_flag_reg <= 1'b0;
      rqs_reg <= 1'b0;
      svc_prev_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
      count_reg <= count_next;
      q_flag_reg <= q_flag_next;
      esr_flag_reg <= esr_flag_next;
      rqs_reg <= rqs_next;
      svc_prev_reg <= svc;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sre_reg <= SBQ_SRE_RESET;
    end else if (cmd_in.sre_wr) begin
      sre_reg <= sre_data_in & SBQ_SRE_WMASK;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stb_out <= SBQ_STB_RESET;
      poll_byte_out <= SBQ_STB_RESET;
    end else begin
      stb_out <= stb_base | ({7'h00, svc} << SBQ_BIT_RQS);
      poll_byte_out <= stb_base | ({7'h00, rqs_next} << SBQ_BIT_RQS);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      err_code_out <= SBQ_CODE_NONE;
      err_valid_out <= 1'b0;
    end else begin
      err_valid_out <= cmd_in.err_query;
      if (cmd_in.err_query) begin
        err_code_out <= pop ? mem[rd_reg] : SBQ_CODE_NONE;
      end
    end
  end

  assign srq_out = rqs_reg;
  assign sre_out = sre_reg;
  assign queue_count_out = count_reg;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_push_when_full;
    push_req && !cmd_in.cls && !pop && count_reg == SBQ_DEPTH_P;
  endsequence
  sequence s_overflow_held;
    count_reg == SBQ_DEPTH_P ##0 mem[sbq_wrap(rd_reg, SBQ_DEPTH_P - SBQ_PTR_ONE)] == SBQ_CODE_OVERFLOW;
  endsequence

  a_prot_bit: assert property (status_in.prot_event |=> stb_out[SBQ_BIT_PROT])
    else $error("protection bit missing");
  a_queue_flag: assert property (push_req |=> q_flag_reg ##1 stb_out[SBQ_BIT_QUEUE])
    else $error("queue bit not set after push");
  a_unused_zero: assert property ((stb_out & SBQ_UNUSED_BITS) == 8'h00
    && (poll_byte_out & SBQ_UNUSED_BITS) == 8'h00) else $error("unused bit set");
  a_mav_gpib: assert property (!status_in.gpib_sel |=> !stb_out[SBQ_BIT_MAV])
    else $error("message bit outside gpib");
  a_esr_read: assert property (cmd_in.esr_read && !status_in.esr_any |=> !esr_flag_reg
    ##1 !stb_out[SBQ_BIT_ESR]) else $error("esr summary not cleared");
  a_rqs_cleared: assert property (cmd_in.poll_done && !svc_rise |=> !srq_out)
    else $error("rqs kept after poll");
  a_mss_status: assert property (svc |=> stb_out[SBQ_BIT_RQS])
    else $error("mss missing from status byte");
  a_poll_rqs: assert property (poll_byte_out[SBQ_BIT_RQS] == srq_out)
    else $error("poll byte bit 6 is not rqs");
  a_mask_gate: assert property ((sre_reg & stb_base) == 8'h00 |-> !svc)
    else $error("unmasked bit raised request");
  a_depth_cap: assert property (count_reg <= SBQ_DEPTH_P)
    else $error("queue above ten");
  a_fifo_order: assert property (pop && !cmd_in.cls |=> err_valid_out
    && err_code_out == $past(mem[rd_reg])) else $error("oldest entry not returned");
  a_cls_empty: assert property (cmd_in.cls && !push_req |=> count_reg == SBQ_PTR_ZERO)
    else $error("clear left entries");
  a_empty_zero: assert property (cmd_in.err_query && count_reg == SBQ_PTR_ZERO
    |=> err_valid_out && err_code_out == SBQ_CODE_NONE) else $error("empty query not zero");
  a_syntax_code: assert property (cmd_in.syntax_err && !cmd_in.cls && count_reg == 4'h0
    |=> mem[rd_reg] == SBQ_CODE_SYNTAX) else $error("syntax code not queued");
  a_get_silent: assert property (cmd_in.get_cmd && !push_req && !pop && !cmd_in.cls
    |=> $stable(count_reg)) else $error("trigger event queued a code");
  a_overflow_code: assert property (s_push_when_full |=> s_overflow_held)
    else $error("overflow code not placed");
  a_queue_drain: assert property (pop && count_reg == SBQ_PTR_ONE && !push_req
    |=> !q_flag_reg) else $error("queue bit kept on empty");
  a_rqs_edge: assert property (svc_rise && !cmd_in.poll_done |=> srq_out)
    else $error("rqs not set on rising condition");

  sequence s_lone_push;
    push_req && !cmd_in.cls && !pop && count_reg == SBQ_PTR_ZERO;
  endsequence
  sequence s_lone_pop;
    pop && !push_req && !cmd_in.cls;
  endsequence

  // second set of checks: hold, clear and decode paths
  a_prot_drop: assert property (!status_in.prot_event
    |=> !stb_out[SBQ_BIT_PROT])
    else $error("protection bit stuck");
  a_flag_count: assert property (count_reg != SBQ_PTR_ZERO
    |-> q_flag_reg)
    else $error("queue bit low with entries");
  a_mav_on: assert property (status_in.mav && status_in.gpib_sel
    |=> stb_out[SBQ_BIT_MAV])
    else $error("message bit missing on gpib");
  a_esr_set: assert property (status_in.esr_any
    |=> esr_flag_reg)
    else $error("esr summary not set");
  a_rqs_hold: assert property (rqs_reg && !cmd_in.poll_done
    |=> srq_out)
    else $error("rqs dropped without poll");
  a_mss_drop: assert property (!svc
    |=> !stb_out[SBQ_BIT_RQS])
    else $error("mss without a reason");
  a_sre_bit6: assert property (sre_out[SBQ_BIT_RQS] == 1'b0
    && $stable(sre_out) || $past(cmd_in.sre_wr))
    else $error("mask bit six set or mask moved");
  a_sre_load: assert property (cmd_in.sre_wr
    |=> sre_out == ($past(sre_data_in) & SBQ_SRE_WMASK))
    else $error("mask not loaded");
  a_count_push: assert property (push_req && !cmd_in.cls && !pop && count_reg < SBQ_DEPTH_P
    |=> count_reg == $past(count_reg) + SBQ_PTR_ONE)
    else $error("push did not add one entry");
  a_pop_count: assert property (s_lone_pop
    |=> count_reg == $past(count_reg) - SBQ_PTR_ONE)
    else $error("pop did not remove one entry");
  a_pop_advance: assert property (pop && !cmd_in.cls
    |=> rd_reg == sbq_wrap($past(rd_reg), SBQ_PTR_ONE))
    else $error("read pointer not advanced");
  a_valid_low: assert property (!cmd_in.err_query
    |=> !err_valid_out && $stable(err_code_out))
    else $error("answer moved without a query");
  a_cls_pointer: assert property (cmd_in.cls
    |=> rd_reg == SBQ_PTR_ZERO)
    else $error("clear left read pointer");
  a_cls_flag: assert property (cmd_in.cls && !push_req
    |=> !q_flag_reg)
    else $error("clear left queue bit");
  a_code_kept: assert property (s_lone_push ##0 cmd_in.err_push && !cmd_in.syntax_err
    && !trig_no_arm |=> mem[rd_reg] == $past(err_code_in))
    else $error("pushed code altered");
  a_trig_code: assert property (s_lone_push ##0 trig_no_arm && !cmd_in.syntax_err
    |=> mem[rd_reg] == SBQ_CODE_NO_TRIG)
    else $error("trigger code not queued");
  a_armed_silent: assert property (cmd_in.trigger_type_command_cmd && cmd_in.trig_armed
    && !cmd_in.syntax_err && !cmd_in.err_push && !pop && !cmd_in.cls |=> $stable(count_reg))
    else $error("armed trigger queued a code");
  a_full_drop: assert property (s_push_when_full
    |=> $stable(rd_reg) && count_reg == SBQ_DEPTH_P)
    else $error("full queue moved");
  a_poll_only: assert property ((poll_byte_out & 8'hBF) == (stb_out & 8'hBF))
    else $error("poll byte differs beyond rqs");
  a_rqs_quiet: assert property (!svc_rise && !rqs_reg
    |=> !srq_out)
    else $error("rqs without rising condition");
endmodule : sbq_status_core

//--- bench/sbq_host_model.sv
// Purpose: remote host that answers a service request with a serial poll
// Assumes: the poll is made delay_in cycles after the request is seen
// Notes: one poll per request; it idles a cycle after each poll so one request is polled once
`timescale 1ns/1ps
module sbq_host_model (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic srq_in,
  input wire logic [7:0] poll_byte_in,
  input wire logic [3:0] delay_in,
  output logic poll_done_out,
  output logic [7:0] polled_out
);
  logic [3:0] wait_reg;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_reg <= 4'h0;
      poll_done_out <= 1'b0;
      polled_out <= 8'h00;
    end else begin
      poll_done_out <= 1'b0;
      if (poll_done_out || !srq_in) begin
        wait_reg <= 4'h0;
      end else if (wait_reg == delay_in) begin
        poll_done_out <= 1'b1;
        polled_out <= poll_byte_in;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : sbq_host_model

//--- bench/tb_sbq_status_core.sv
// Purpose: self-checking bench for the status byte and error queue
// Assumes: one-cycle command pulses, answers checked through expectation queues
// Notes: a pulse is followed by an idle cycle, which the core allows
`timescale 1ns/1ps
module tb_sbq_status_core;
  import sbq_pkg::*;
  localparam int CLS = 9, QRY = 8, PSH = 7, SYN = 6, TRG = 5, GET = 3, SRE = 2, STANDARD_EVENT_REGISTER = 1;
  logic ref_clk = 0, nrst = 0, armed = 0, srq, vld, pd;
  logic [3:0] cnt;
  logic [7:0] stb, pb, sre, polled;
  logic [15:0] dat = 16'h0000;
  sbq_cmd_s cmd = '0, cmd_w;
  sbq_status_s st = '0;
  sbq_code_t code, ref_q[$], exp_q[$];
  logic [7:0] poll_q[$];
  int failures = 0, checked = 0, cycles = 0;
  always #4 ref_clk = ~ref_clk;
  always_comb begin
    cmd_w = cmd;
    cmd_w.trig_armed = armed;
    cmd_w.poll_done = pd;
  end
  sbq_status_core dut (.ref_clk_in(ref_clk), .nrst_in(nrst), .status_in(st), .cmd_in(cmd_w),
    .err_code_in(dat), .sre_data_in(dat[7:0]), .stb_out(stb), .poll_byte_out(pb),
    .srq_out(srq), .sre_out(sre), .err_code_out(code), .err_valid_out(vld),
    .queue_count_out(cnt));
  sbq_host_model host (.ref_clk_in(ref_clk), .nrst_in(nrst), .srq_in(srq),
    .poll_byte_in(pb), .delay_in(4'h2), .poll_done_out(pd), .polled_out(polled));
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task pulse(input int b, input logic [15:0] d);
    @(posedge ref_clk);
    cmd <= sbq_cmd_s'(10'd1 << b);
    dat <= d;
    @(posedge ref_clk);
    cmd <= '0;
  endtask : pulse
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task query(input sbq_code_t e);
    exp_q.push_back(e);
    pulse(QRY, 16'h0000);
  endtask : query
  // registered outputs are read mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
    if (vld === 1'b1) check("err_code", code, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    if (pd === 1'b1) check("poll_byte", {8'h00, polled}, poll_q.pop_front());
  end
  initial begin
    sbq_code_t r;
    void'($urandom(43574));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    settle(1);
    check("reset_stb", {8'h00, stb}, {8'h00, SBQ_STB_RESET});
    check("reset_sre", {8'h00, sre}, {8'h00, SBQ_SRE_RESET});
    query(SBQ_CODE_NONE);
    pulse(SYN, 16'h0000);
    pulse(TRG, 16'h0000);
    @(posedge ref_clk) armed <= 1'b1;
    pulse(TRG, 16'h0000);
    pulse(GET, 16'h0000);
    @(posedge ref_clk) armed <= 1'b0;
    ref_q = '{SBQ_CODE_SYNTAX, SBQ_CODE_NO_TRIG};
    for (int i = 0; i < 10; i++) begin
      r = sbq_code_t'($urandom);
      if (i < 7) ref_q.push_back(r);
      pulse(PSH, r);
    end
    ref_q.push_back(SBQ_CODE_OVERFLOW);
    settle(1);
    check("count_full", {12'h000, cnt}, 16'h000A);
    check("stb_queue", {15'h0000, stb[SBQ_BIT_QUEUE]}, 16'h0001);
    while (ref_q.size()) query(ref_q.pop_front());
    query(SBQ_CODE_NONE);
    settle(3);
    check("stb_drained", {8'h00, stb}, 16'h0000);
    $display("queue test done");
    repeat (3) pulse(PSH, 16'($urandom));
    pulse(CLS, 16'h0000);
    settle(1);
    check("count_cls", {12'h000, cnt}, 16'h0000);
    query(SBQ_CODE_NONE);
    $display("clear test done");
    @(posedge ref_clk) st <= '{prot_event: 0, esr_any: 0, mav: 1, gpib_sel: 0};
    settle(3);
    check("mav_serial", {8'h00, stb}, 16'h0000);
    @(posedge ref_clk) st.gpib_sel <= 1'b1;
    settle(3);
    check("mav_gpib", {8'h00, stb}, 16'h0010);
    check("srq_masked", {15'h0000, srq}, 16'h0000);
    // enabling every writable bit makes the waiting message raise a request of its own
    poll_q.push_back(8'h50);
    pulse(SRE, 16'h00FF);
    settle(1);
    check("sre_readback", {8'h00, sre}, {8'h00, SBQ_SRE_WMASK});
    pulse(SRE, 16'h0002);
    poll_q.push_back(8'h42);
    @(posedge ref_clk) st <= '{prot_event: 1, esr_any: 0, mav: 0, gpib_sel: 1};
    settle(8);
    check("srq_after_poll", {15'h0000, srq}, 16'h0000);
    check("poll_after", {8'h00, pb}, 16'h0002);
    check("stb_mss", {8'h00, stb}, 16'h0042);
    check("stb_unused", {8'h00, stb & SBQ_UNUSED_BITS}, 16'h0000);
    @(posedge ref_clk) st.esr_any <= 1'b1;
    settle(3);
    check("esr_set", {15'h0000, stb[SBQ_BIT_ESR]}, 16'h0001);
    @(posedge ref_clk) st.esr_any <= 1'b0;
    pulse(STANDARD_EVENT_REGISTER, 16'h0000);
    settle(2);
    check("esr_clear", {15'h0000, stb[SBQ_BIT_ESR]}, 16'h0000);
    $display("status test done");
    results();
  end
endmodule : tb_sbq_status_core
